// *** hdl/sfrw_core.sv ***
// Serial flash instruction sequencer: status, reads, page write/program
`timescale 1ns/1ns
// Functional notes
// RQ1 - Status byte returned anytime, repeated while clocked
// RQ2 - Busy flag bit0 high during internal cycle
// RQ3 - Permit latch reported; cleared latch refuses writes
// RQ4 - Bits 7..2 zero; flags not host writable
// RQ5 - Host should poll busy before new instruction
// RQ6 - Read: code, 24-bit address, data on falls
// RQ7 - Read address increments, wraps to zero
// RQ8 - Address bits 23..18 ignored
// RQ9 - Fast read inserts one dummy byte
// RQ10 - Select high ends read, stops driving
// RQ11 - Reads refused while internal cycle runs
// RQ12 - Write commands need permit latch set
// RQ13 - Host holds select through write sequence
// RQ14 - Page write stores sent bytes, keeps others
// RQ15 - Data past page end wraps to offset zero
// RQ16 - Only last 256 bytes kept
// RQ17 - Select rise off byte boundary discards write
// RQ18 - Select rise starts timed cycle, clears latch
// RQ19 - Page program only clears bits
// RQ20 - Protected pages never written
// RQ21 - Writes refused while internal cycle runs
// RQ22 - Host should batch bytes per page
// RQ23 - Serial data most significant bit first
// RQ24 - Codes 05h status, 03h read, 0Bh fast
// RQ25 - Codes 0Ah rewrite, 02h program, 1..256 bytes
// RQ26 - Select fall restarts decode at instruction byte
module sfrw_core #(
  parameter int ADDR_W = 18,
  parameter int FIFO_DEPTH = 16,
  parameter int PROT_PAGES = 256,
  parameter int REWRITE_CYC = sfrw_pkg::PAGE_REWRITE_CYC,
  parameter int PROGRAM_CYC = sfrw_pkg::PAGE_PROGRAM_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic protect_i,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic [7:0] mem_rdata_i,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  output logic busy_flag_o,
  output logic write_permit_latch_o
);
  localparam int PAGE_W = ADDR_W - 8;
  localparam logic [PAGE_W-1:0] PROT_LIMIT = PAGE_W'(PROT_PAGES);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [3:0] sync_q;
  logic sclk_q;
  logic cs_n_q;
  sfrw_sync #(.W(4), .RST_VAL(4'h4)) u_sync (
    .clk_i(sys_clk_i),
    .rst_i(sys_rst_i),
    .d_i({spi_clk_i, spi_cs_n_i, spi_mosi_i, protect_i}),
    .q_o(sync_q)
  );
  wire sclk_s = sync_q[3];
  wire cs_n_s = sync_q[2];
  wire mosi_s = sync_q[1];
  wire prot_s = sync_q[0];
  wire selected = !cs_n_s;
  wire sclk_rise = selected && sclk_s && !sclk_q;
  wire sclk_fall = selected && !sclk_s && sclk_q;
  wire cs_fall = !cs_n_s && cs_n_q;
  wire cs_rise = cs_n_s && !cs_n_q;

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  sfrw_pkg::sfrw_phase_t phase;
  sfrw_pkg::sfrw_phase_t next_phase;
  sfrw_pkg::sfrw_eng_t eng;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] cmd;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wr_off;
  logic fetching;
  logic rd_d;
  logic busy;
  logic write_permit_latch;
  logic [7:0] page_mem [256];
  logic [255:0] page_vld;
  logic [PAGE_W-1:0] eng_page;
  logic [7:0] eng_off;
  logic eng_prog;
  logic [31:0] tmr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  wire eng_active = (eng != sfrw_pkg::EN_IDLE);

  wire [7:0] next_byte = {shift_in[6:0], mosi_s}; // RQ23
  wire byte_done = sclk_rise && (bit_cnt == sfrw_pkg::BYTE_LAST_BIT);
  wire is_read = (cmd == sfrw_pkg::READ_CMD) ||
                 (cmd == sfrw_pkg::FAST_READ_CMD);
  wire [7:0] status_byte = {6'h00, write_permit_latch, busy}; // RQ4
  wire out_phase = (phase == sfrw_pkg::PH_STAT) ||
                   (phase == sfrw_pkg::PH_RDATA);
  wire load_out = sclk_fall && out_phase && (bit_cnt == 3'd0);
  wire pop = load_out && (phase == sfrw_pkg::PH_RDATA);

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  logic [7:0] dec_code;
  assign dec_code = next_byte;
  wire code_read = (dec_code == sfrw_pkg::READ_CMD) ||
                   (dec_code == sfrw_pkg::FAST_READ_CMD); // RQ24
  wire code_write = (dec_code == sfrw_pkg::PAGE_REWRITE_CMD) ||
                    (dec_code == sfrw_pkg::PAGE_PROGRAM_CMD); // RQ25
  wire addr_last = (byte_cnt == sfrw_pkg::ADDR_BYTES);

  always_comb begin
    next_phase = phase;
    unique case (phase)
      sfrw_pkg::PH_CMD: begin
        if (dec_code == sfrw_pkg::STATUS_READ_CMD) begin
          next_phase = sfrw_pkg::PH_STAT; // RQ1
        end else if (code_read) begin
          next_phase = busy ? sfrw_pkg::PH_IGNORE
                            : sfrw_pkg::PH_ADDR; // RQ11
        end else if (code_write) begin
          next_phase = (busy || !write_permit_latch) ? sfrw_pkg::PH_IGNORE
                                      : sfrw_pkg::PH_ADDR; // RQ12 RQ21 RQ3
        end else begin
          next_phase = sfrw_pkg::PH_IGNORE;
        end
      end
      sfrw_pkg::PH_ADDR: begin
        if (addr_last) begin
          if (!is_read) begin
            next_phase = sfrw_pkg::PH_WDATA;
          end else if (cmd == sfrw_pkg::FAST_READ_CMD) begin
            next_phase = sfrw_pkg::PH_DUMMY; // RQ9
          end else begin
            next_phase = sfrw_pkg::PH_RDATA; // RQ6
          end
        end
      end
      sfrw_pkg::PH_DUMMY: next_phase = sfrw_pkg::PH_RDATA;
      sfrw_pkg::PH_RDATA: next_phase = phase;
      sfrw_pkg::PH_WDATA: next_phase = phase;
      sfrw_pkg::PH_STAT: next_phase = phase;
      sfrw_pkg::PH_IGNORE: next_phase = phase;
      default: next_phase = sfrw_pkg::PH_IGNORE;
    endcase
  end

  // ----------------------------------------------------------------
  // Write acceptance at the end of the frame
  // ----------------------------------------------------------------
  wire at_boundary = (bit_cnt == 3'd0);
  wire prot_hit = prot_s && (addr[ADDR_W-1:8] < PROT_LIMIT);
  wire write_go = cs_rise && (phase == sfrw_pkg::PH_WDATA) &&
                  at_boundary && (byte_cnt > sfrw_pkg::FIRST_DATA_BYTE) &&
                  !prot_hit; // RQ17 RQ20
  wire permit_go = cs_rise && (cmd == sfrw_pkg::WRITE_PERMIT_CMD) &&
                   at_boundary && (byte_cnt == 3'd1) && !busy;

  // ----------------------------------------------------------------
  // Serial receive side
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase <= sfrw_pkg::PH_CMD;
      bit_cnt <= 3'd0;
      byte_cnt <= 3'd0;
      shift_in <= 8'h00;
      cmd <= 8'h00;
    end else if (cs_fall) begin
      phase <= sfrw_pkg::PH_CMD; // RQ26
      bit_cnt <= 3'd0;
      byte_cnt <= 3'd0;
      cmd <= 8'h00;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 3'd1;
      shift_in <= next_byte;
      if (byte_done) begin
        phase <= next_phase;
        if (byte_cnt != 3'd7) byte_cnt <= byte_cnt + 3'd1;
        if (phase == sfrw_pkg::PH_CMD) cmd <= dec_code;
      end
    end
  end

  // Address register also serves as the read pointer once fetching
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr <= '0;
    end else if (sclk_rise && phase == sfrw_pkg::PH_ADDR) begin
      addr <= {addr[ADDR_W-2:0], mosi_s}; // RQ8
    end else if (fetching && !eng_active && !mem_rd_o && !rd_d &&
                 fifo_in_ready) begin
      addr <= addr + 1'b1; // RQ7
    end
  end

  // ----------------------------------------------------------------
  // Page buffer fill
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_off <= 8'h00;
      page_vld <= '0;
    end else if (cs_fall && !busy) begin
      page_vld <= '0;
    end else if (byte_done) begin
      if (phase == sfrw_pkg::PH_ADDR && addr_last) begin
        wr_off <= next_byte;
      end else if (phase == sfrw_pkg::PH_WDATA) begin
        wr_off <= wr_off + 8'd1; // RQ15
        page_vld[wr_off] <= 1'b1; // RQ16
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (byte_done && phase == sfrw_pkg::PH_WDATA) begin
      page_mem[wr_off] <= next_byte; // RQ16
    end
  end

  // ----------------------------------------------------------------
  // Read prefetch through the FIFO
  // ----------------------------------------------------------------
  sfrw_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(sys_clk_i),
    .rst_i(sys_rst_i),
    .flush_i(!selected),
    .in_valid_i(rd_d && fetching),
    .in_ready_o(fifo_in_ready),
    .in_data_i(mem_rdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data)
  );

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetching <= 1'b0;
    end else if (!selected) begin
      fetching <= 1'b0; // RQ10
    end else if (byte_done && phase == sfrw_pkg::PH_ADDR && addr_last &&
                 is_read) begin
      fetching <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Serial transmit side, shifted on falling clock edges
  // ----------------------------------------------------------------
  wire [7:0] out_byte = (phase == sfrw_pkg::PH_STAT) ? status_byte // RQ1
                      : (fifo_out_valid ? fifo_out_data : 8'h00);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_out <= 8'h00;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else if (!selected) begin
      spi_miso_oe_o <= 1'b0; // RQ10
    end else if (load_out) begin
      spi_miso_o <= out_byte[7]; // RQ23
      shift_out <= {out_byte[6:0], 1'b0};
      spi_miso_oe_o <= 1'b1;
    end else if (sclk_fall && out_phase) begin
      spi_miso_o <= shift_out[7]; // RQ6
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Self-timed page cycle engine
  // ----------------------------------------------------------------
  // Only sent bytes are touched, so the rest of the page keeps its data
  wire [7:0] wr_value = eng_prog ? (mem_rdata_i & page_mem[eng_off]) // RQ19
                                 : page_mem[eng_off]; // RQ14

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      eng <= sfrw_pkg::EN_IDLE;
      eng_page <= '0;
      eng_off <= 8'h00;
      eng_prog <= 1'b0;
      tmr <= '0;
    end else begin
      if (tmr != 0) tmr <= tmr - 1;
      unique case (eng)
        sfrw_pkg::EN_IDLE: begin
          if (write_go) begin
            eng <= sfrw_pkg::EN_SCAN; // RQ18
            eng_page <= addr[ADDR_W-1:8];
            eng_off <= 8'h00;
            eng_prog <= (cmd == sfrw_pkg::PAGE_PROGRAM_CMD);
            tmr <= (cmd == sfrw_pkg::PAGE_PROGRAM_CMD) ? PROGRAM_CYC
                                                       : REWRITE_CYC;
          end
        end
        sfrw_pkg::EN_SCAN: begin
          if (page_vld[eng_off]) begin
            eng <= sfrw_pkg::EN_READ;
          end else if (eng_off == sfrw_pkg::PAGE_LAST_OFFSET) begin
            eng <= sfrw_pkg::EN_WAIT;
          end else begin
            eng_off <= eng_off + 8'd1;
          end
        end
        sfrw_pkg::EN_READ: eng <= sfrw_pkg::EN_WRITE;
        sfrw_pkg::EN_WRITE: begin
          if (eng_off == sfrw_pkg::PAGE_LAST_OFFSET) begin
            eng <= sfrw_pkg::EN_WAIT;
          end else begin
            eng <= sfrw_pkg::EN_SCAN;
            eng_off <= eng_off + 8'd1;
          end
        end
        sfrw_pkg::EN_WAIT: begin
          if (tmr == 0) eng <= sfrw_pkg::EN_IDLE;
        end
        default: eng <= sfrw_pkg::EN_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Array port, shared by prefetch and engine (never both at once)
  // ----------------------------------------------------------------
  wire fetch_issue = fetching && !eng_active && !mem_rd_o && !rd_d &&
                     fifo_in_ready;
  wire eng_issue = (eng == sfrw_pkg::EN_SCAN) && page_vld[eng_off];

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_addr_o <= '0;
      mem_rd_o <= 1'b0;
      rd_d <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= 8'h00;
    end else begin
      rd_d <= mem_rd_o;
      mem_rd_o <= fetch_issue || eng_issue;
      mem_wr_o <= (eng == sfrw_pkg::EN_WRITE);
      if (eng_issue) mem_addr_o <= {eng_page, eng_off};
      else if (fetch_issue) mem_addr_o <= addr;
      if (eng == sfrw_pkg::EN_WRITE) mem_wdata_o <= wr_value;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy <= sfrw_pkg::STATUS_RESET[sfrw_pkg::BUSY_BIT];
      write_permit_latch <= sfrw_pkg::STATUS_RESET[sfrw_pkg::PERMIT_BIT];
    end else begin
      if (write_go) begin
        busy <= 1'b1; // RQ2
        write_permit_latch <= 1'b0; // RQ18
      end else begin
        if (eng == sfrw_pkg::EN_WAIT && tmr == 0) busy <= 1'b0; // RQ2
        if (permit_go) write_permit_latch <= 1'b1; // RQ3
      end
    end
  end

  assign busy_flag_o = busy;
  assign write_permit_latch_o = write_permit_latch;
endmodule : sfrw_core

// *** shared/sfrw_pkg.sv ***
// Shared constants and types of the serial flash instruction sequencer
package sfrw_pkg;
  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] FAST_READ_CMD = 8'h0b;
  localparam logic [7:0] PAGE_REWRITE_CMD = 8'h0a;
  localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] WRITE_PERMIT_CMD = 8'h06;
  // ----------------------------------------------------------------
  // Status byte layout and frame counts
  // ----------------------------------------------------------------
  localparam int BUSY_BIT = 0;
  localparam int PERMIT_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] ADDR_BYTES = 3'd3;
  localparam logic [2:0] FIRST_DATA_BYTE = 3'd4;
  localparam logic [2:0] BYTE_LAST_BIT = 3'd7;
  localparam logic [7:0] PAGE_LAST_OFFSET = 8'hff;
  // ----------------------------------------------------------------
  // Self-timed cycle durations
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PAGE_REWRITE_TIME_US = 1000;
  localparam int PAGE_PROGRAM_TIME_US = 100;
  localparam int PAGE_REWRITE_CYC = PAGE_REWRITE_TIME_US * CLK_MHZ;
  localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b010,
    PH_RDATA = 3'b011,
    PH_WDATA = 3'b100,
    PH_STAT = 3'b101,
    PH_IGNORE = 3'b110
  } sfrw_phase_t;
  typedef enum logic [2:0] {
    EN_IDLE = 3'b000,
    EN_SCAN = 3'b001,
    EN_READ = 3'b010,
    EN_WRITE = 3'b011,
    EN_WAIT = 3'b100
  } sfrw_eng_t;
endpackage : sfrw_pkg

// *** hdl/sfrw_sync.sv ***
// Two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/1ns
module sfrw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : sfrw_sync

// *** hdl/sfrw_fifo.sv ***
// Flushable synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sfrw_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) &&
                        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push && !flush_i) mem[wr_ptr[AW-1:0]] <= in_data_i;
  end
endmodule : sfrw_fifo

// *** test/sfrw_core_props.sv ***
// Port-level concurrent checks for the serial flash sequencer
`timescale 1ns/1ns
module sfrw_core_props #(
  parameter int ADDR_W = 18,
  parameter int REWRITE_CYC = 1000,
  parameter int PROGRAM_CYC = 1000
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_oe_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic busy_flag_o,
  input wire logic write_permit_latch_o
);
  localparam int LO = (PROGRAM_CYC < REWRITE_CYC) ? PROGRAM_CYC : REWRITE_CYC;
  localparam int HI = (PROGRAM_CYC < REWRITE_CYC) ? REWRITE_CYC : PROGRAM_CYC;
  // Scan of 256 offsets may stretch the cycle; slack covers it
  logic [31:0] run_cnt;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_cnt <= '0;
    end else begin
      run_cnt <= busy_flag_o ? run_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence cs_release;
    $rose(spi_cs_n_i);
  endsequence
  sequence cycle_start;
    $rose(busy_flag_o);
  endsequence
  oe_drop_a: assert property (cs_release |-> ##[1:6] !spi_miso_oe_o)
    else $error("miso drive held after select release");
  oe_idle_a: assert property (spi_cs_n_i [*8] |-> !spi_miso_oe_o)
    else $error("miso driven while deselected");
  start_lock_a: assert property (cycle_start |-> spi_cs_n_i && !write_permit_latch_o)
    else $error("cycle start without select high and latch clear");
  start_cause_a: assert property (cycle_start |-> $past(write_permit_latch_o))
    else $error("cycle started without permit latch");
  latch_set_a: assert property ($rose(write_permit_latch_o) |-> spi_cs_n_i && !busy_flag_o)
    else $error("permit latch set mid frame or while busy");
  wr_busy_a: assert property (mem_wr_o |-> busy_flag_o && !mem_rd_o)
    else $error("array write outside a timed cycle");
  wr_pair_a: assert property (mem_wr_o |-> $past(mem_rd_o, 2) && mem_addr_o == $past(mem_addr_o, 2))
    else $error("array write not preceded by read of same byte");
  busy_min_a: assert property ($fell(busy_flag_o) |-> run_cnt >= LO - 1)
    else $error("busy cleared before cycle time");
  busy_max_a: assert property (run_cnt <= HI + 4000)
    else $error("busy flag never clears");
endmodule : sfrw_core_props

bind sfrw_core sfrw_core_props #(
  .ADDR_W(ADDR_W),
  .REWRITE_CYC(REWRITE_CYC),
  .PROGRAM_CYC(PROGRAM_CYC)
) u_props (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .spi_cs_n_i(spi_cs_n_i),
  .spi_miso_oe_o(spi_miso_oe_o),
  .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o),
  .mem_wr_o(mem_wr_o),
  .busy_flag_o(busy_flag_o),
  .write_permit_latch_o(write_permit_latch_o)
);

// *** test/sfrw_host.sv ***
// Behavioural SPI host driving mode 0 frames at 160 ns per bit
`timescale 1ns/1ns
module sfrw_host (
  input wire logic clk_i,
  output logic spi_clk_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i
);
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  task automatic sel();
    @(posedge clk_i);
    spi_cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : sel
  task automatic desel();
    repeat (4) @(posedge clk_i);
    spi_cs_n_o <= 1'b1;
    // Released data line toggles so no stale level is mistaken
    spi_mosi_o <= ~spi_mosi_o;
    repeat (8) @(posedge clk_i);
  endtask : desel
  // Clock stands low outside frames; nbits below 8 cuts a byte short
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      input int nbits);
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk_i);
      spi_mosi_o <= tx[7-i];
      repeat (7) @(posedge clk_i);
      spi_clk_o <= 1'b1;
      rx[7-i] = spi_miso_i;
      repeat (8) @(posedge clk_i);
      spi_clk_o <= 1'b0;
    end
  endtask : xfer
endmodule : sfrw_host

// *** test/testbench.sv ***
// Self-checking bench: SPI frames into the sequencer over a byte array
`timescale 1ns/1ns
module testbench;
  localparam int AW = 18;
  logic clk;
  logic rst;
  logic protect;
  logic spi_clk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic [AW-1:0] mem_addr;
  logic mem_rd;
  logic [7:0] mem_rdata;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic busy;
  logic permit;
  logic saw_oe;
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rb [0:3];
  logic [7:0] st;
  logic [7:0] st2;
  int failures;
  int checked;
  wire logic miso_w;
  assign miso_w = miso_oe ? miso : 1'b1;
  initial clk = 1'b0;
  always #5 clk = ~clk;
  sfrw_core #(.PROT_PAGES(4), .REWRITE_CYC(1000), .PROGRAM_CYC(1000)) dut (
    .sys_clk_i(clk), .sys_rst_i(rst), .spi_clk_i(spi_clk),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .protect_i(protect), .mem_addr_o(mem_addr),
    .mem_rd_o(mem_rd), .mem_rdata_i(mem_rdata), .mem_wr_o(mem_wr),
    .mem_wdata_o(mem_wdata), .busy_flag_o(busy),
    .write_permit_latch_o(permit));
  sfrw_host host (.clk_i(clk), .spi_clk_o(spi_clk), .spi_cs_n_o(cs_n),
    .spi_mosi_o(mosi), .spi_miso_i(miso_w));
  // Array model; idle read data keeps changing so stale bytes show
  always @(posedge clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (miso_oe) begin
      saw_oe <= 1'b1;
    end
  end
  function automatic logic [7:0] pat(input logic [AW-1:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : pat
  function automatic logic [7:0] wval(input int k);
    return (k < 256) ? (8'(k) ^ 8'hc3) : 8'hee;
  endfunction : wval
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rd_status();
    logic [7:0] r;
    host.sel();
    host.xfer(sfrw_pkg::STATUS_READ_CMD, r, 8);
    host.xfer(8'h00, st, 8);
    host.xfer(8'h00, st2, 8);
    host.desel();
  endtask : rd_status
  task automatic head(input logic [7:0] code, input logic [23:0] a);
    logic [7:0] r;
    host.sel();
    host.xfer(code, r, 8);
    for (int i = 2; i >= 0; i--) begin
      host.xfer(a[8*i +: 8], r, 8);
    end
  endtask : head
  task automatic rd(input logic [7:0] code, input logic [23:0] a,
                    input int n, input int tail);
    logic [7:0] r;
    head(code, a);
    if (code == sfrw_pkg::FAST_READ_CMD) begin
      host.xfer(8'h00, r, 8);
    end
    for (int i = 0; i < n; i++) begin
      host.xfer(8'h00, rb[i], 8);
    end
    host.xfer(8'h00, r, tail);
    host.desel();
  endtask : rd
  task automatic wr(input logic [7:0] code, input logic [23:0] a,
                    input int n, input int tail);
    logic [7:0] r;
    head(code, a);
    for (int k = 0; k < n; k++) begin
      host.xfer(wval(k), r, 8);
    end
    host.xfer(8'h00, r, tail);
    host.desel();
  endtask : wr
  task automatic permit_on();
    logic [7:0] r;
    host.sel();
    host.xfer(sfrw_pkg::WRITE_PERMIT_CMD, r, 8);
    host.desel();
  endtask : permit_on
  task automatic wait_idle();
    for (int i = 0; i < 30; i++) begin
      rd_status();
      if (st[0] === 1'b0) begin
        break;
      end
    end
    chk("busy after cycle", st & 8'h01, 8'h00);
  endtask : wait_idle
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (95000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    protect = 1'b0;
    mem_rdata = 8'h00;
    saw_oe = 1'b0;
    failures = 0;
    checked = 0;
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = pat(AW'(i));
    end
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_status();
    chk("status at reset", st, 8'h00);
    chk("status repeat", st2, st);
    permit_on();
    chk("latch pin", {7'h00, permit}, 8'h01);
    rd_status();
    chk("status latch", st, 8'h02);
    rd(sfrw_pkg::READ_CMD, 24'hfffffe, 4, 3);
    chk("read top", rb[0], pat(18'h3fffe));
    chk("read top+1", rb[1], pat(18'h3ffff));
    chk("read wrap", rb[2], pat(18'h00000));
    chk("read wrap+1", rb[3], pat(18'h00001));
    rd(sfrw_pkg::FAST_READ_CMD, 24'h000100, 2, 0);
    chk("fast read", rb[0], pat(18'h00100));
    chk("fast read+1", rb[1], pat(18'h00101));
    wr(sfrw_pkg::PAGE_PROGRAM_CMD, 24'h0010fe, 3, 0);
    chk("busy pin", {7'h00, busy}, 8'h01);
    rd_status();
    chk("status in cycle", st, 8'h01);
    saw_oe <= 1'b0;
    rd(sfrw_pkg::READ_CMD, 24'h0010fe, 1, 0);
    chk("read while busy", {7'h00, saw_oe}, 8'h00);
    wait_idle();
    rd(sfrw_pkg::READ_CMD, 24'h0010fd, 3, 0);
    chk("untouched byte", rb[0], pat(18'h010fd));
    chk("program fe", rb[1], pat(18'h010fe) & wval(0));
    chk("program ff", rb[2], pat(18'h010ff) & wval(1));
    rd(sfrw_pkg::READ_CMD, 24'h001000, 2, 0);
    chk("program wrap", rb[0], pat(18'h01000) & wval(2));
    chk("after wrap", rb[1], pat(18'h01001));
    wr(sfrw_pkg::PAGE_REWRITE_CMD, 24'h002005, 1, 0);
    rd_status();
    chk("no latch refuse", st & 8'h01, 8'h00);
    permit_on();
    wr(sfrw_pkg::PAGE_REWRITE_CMD, 24'h002005, 1, 3);
    rd_status();
    chk("partial byte", st & 8'h01, 8'h00);
    permit_on();
    wr(sfrw_pkg::PAGE_REWRITE_CMD, 24'h002005, 258, 0);
    wait_idle();
    rd(sfrw_pkg::READ_CMD, 24'h002004, 4, 0);
    chk("rewrite 04", rb[0], wval(255));
    chk("rewrite 05", rb[1], wval(256));
    chk("rewrite 06", rb[2], wval(257));
    chk("rewrite 07", rb[3], wval(2));
    protect <= 1'b1;
    permit_on();
    wr(sfrw_pkg::PAGE_PROGRAM_CMD, 24'h000100, 1, 0);
    rd_status();
    chk("protected busy", st & 8'h01, 8'h00);
    rd(sfrw_pkg::READ_CMD, 24'h000100, 1, 0);
    chk("protected data", rb[0], pat(18'h00100));
    close_out();
  end
endmodule : testbench
